// ==== design/dmc_top.sv ====
// dmc_top: halt, step, injected-instruction, test and reset mode control
// with output checking for a pipelined 32-bit processor.
// assumes the debugger drives controls synchronously to CLK_I.
// Operation
// - the core halts on a halting instruction or an external halt request.
// - while halted nothing is fetched and nothing is executed.
// - a step acts as halt but lets the pipeline advance exactly one stage.
// - in injected mode instructions come from the debugger, not memory.
// - after injected instructions the original program position resumes.
// - test mode turns off every output driver.
// - reset initialises control state and the saved program position.
// - the debugger steers the modes through dedicated inputs and outputs.
// - internal state is readable over the data bus, and writable over it in injected mode only.
// - the core may perform system accesses on the debugger's behalf.
// - every output's pin level is compared with its driver value.
// - a mismatch on an enabled driver raises the error output.
// - a parallel slave keeps drivers off and checks the master's pins.
// - the current mode is shown on status outputs.
`timescale 1ns/1ps
module dmc_top #(
  parameter int PIN_W = dmc_pkg::PIN_W,
  parameter int BUS_W = dmc_pkg::BUS_W
) (
  input  wire logic             CLK_I,
  input  wire logic             RST_N_I,
  input  wire dmc_pkg::dmc_ctrl_t CTRL_I,
  input  wire logic             HALT_INSTR_I,
  input  wire logic [BUS_W-1:0] PC_I,
  input  wire logic [BUS_W-1:0] INJ_INSTR_I,
  input  wire logic             INJ_VALID_I,
  input  wire logic [BUS_W-1:0] MEM_INSTR_I,
  input  wire logic [BUS_W-1:0] DBG_WDATA_I,
  input  wire logic             DBG_WE_I,
  input  wire logic [BUS_W-1:0] STATE_RDATA_I,
  input  wire logic [PIN_W-1:0] DRV_VAL_I,
  input  wire logic [PIN_W-1:0] DRV_OE_I,
  input  wire logic [PIN_W-1:0] PIN_LVL_I,
  output dmc_pkg::dmc_pipe_t    PIPE_O,
  output logic [BUS_W-1:0]      INSTR_O,
  output logic                  INSTR_VALID_O,
  output logic [BUS_W-1:0]      RESUME_PC_O,
  output logic                  RESUME_O,
  output logic [BUS_W-1:0]      STATE_WDATA_O,
  output logic                  STATE_WE_O,
  output logic [BUS_W-1:0]      DBG_RDATA_O,
  output logic [PIN_W-1:0]      PIN_OE_O,
  output logic [2:0]            MODE_O,
  output logic                  CHK_ERR_O
);

  dmc_pkg::dmc_state_t state_ff;
  dmc_pkg::dmc_state_t nxt_state;
  logic [1:0]          step_cnt_ff;
  logic [BUS_W-1:0]    saved_pc_ff;
  logic                resume_ff;
  logic [BUS_W-1:0]    instr_ff;
  logic                instr_vld_ff;
  logic [BUS_W-1:0]    rdata_ff;
  logic [BUS_W-1:0]    wdata_ff;
  logic                we_ff;
  logic [2:0]          mode_ff;
  logic                step_done;

  // decode of state into the debugger-visible mode code
  function automatic logic [2:0] mode_of(input dmc_pkg::dmc_state_t s);
    case (s)
      dmc_pkg::DMC_EXEC:  mode_of = dmc_pkg::MODE_EXEC;
      dmc_pkg::DMC_HALT:  mode_of = dmc_pkg::MODE_HALT;
      dmc_pkg::DMC_STEP:  mode_of = dmc_pkg::MODE_STEP;
      dmc_pkg::DMC_INJ:   mode_of = dmc_pkg::MODE_INJ;
      dmc_pkg::DMC_TEST:  mode_of = dmc_pkg::MODE_TEST;
      default:            mode_of = dmc_pkg::MODE_RESET;
    endcase
  endfunction : mode_of

  // done on the last executing cycle, so the state leaves step after
  // exactly one stage instead of lingering one cycle too long
  assign step_done = ((step_cnt_ff + 2'h1) == dmc_pkg::STEP_CYC);

  // next-state; reset first, then test, halt sources, inject, step
  always_comb begin
    nxt_state = state_ff;
    if (CTRL_I.reset_req) begin
      nxt_state = dmc_pkg::DMC_RESET;
    end else if (CTRL_I.test_req) begin
      nxt_state = dmc_pkg::DMC_TEST;
    end else begin
      case (state_ff)
        dmc_pkg::DMC_RESET: nxt_state = dmc_pkg::DMC_EXEC;
        dmc_pkg::DMC_TEST:  nxt_state = dmc_pkg::DMC_HALT;
        dmc_pkg::DMC_EXEC: begin
          if (CTRL_I.halt_req || HALT_INSTR_I) begin
            nxt_state = dmc_pkg::DMC_HALT;
          end
        end
        dmc_pkg::DMC_HALT: begin
          if (CTRL_I.inject_req) begin
            nxt_state = dmc_pkg::DMC_INJ;
          end else if (CTRL_I.step_req) begin
            nxt_state = dmc_pkg::DMC_STEP;
          end else if (!CTRL_I.halt_req) begin
            nxt_state = dmc_pkg::DMC_EXEC;
          end
        end
        dmc_pkg::DMC_STEP: begin
          // back to halt after one stage, even if step is still held
          if (step_done) begin
            nxt_state = dmc_pkg::DMC_HALT;
          end
        end
        dmc_pkg::DMC_INJ: begin
          if (!CTRL_I.inject_req) begin
            nxt_state = dmc_pkg::DMC_HALT;
          end
        end
        default: nxt_state = dmc_pkg::DMC_RESET;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_ff <= dmc_pkg::DMC_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // step counter: counts executing cycles inside one step
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      step_cnt_ff <= 2'h0;
    end else if (state_ff == dmc_pkg::DMC_STEP) begin
      step_cnt_ff <= step_cnt_ff + 2'h1;
    end else begin
      step_cnt_ff <= 2'h0;
    end
  end

  // program position saved on entry to injected mode, replayed on exit
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || state_ff == dmc_pkg::DMC_RESET) begin
      saved_pc_ff <= dmc_pkg::PC_RST;
      resume_ff   <= 1'b0;
    end else begin
      resume_ff <= 1'b0;
      if (state_ff != dmc_pkg::DMC_INJ && nxt_state == dmc_pkg::DMC_INJ) begin
        saved_pc_ff <= PC_I;
      end
      if (state_ff == dmc_pkg::DMC_INJ && nxt_state != dmc_pkg::DMC_INJ) begin
        resume_ff <= 1'b1;
      end
    end
  end

  // instruction source mux; memory words are ignored while injecting
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      instr_ff     <= '0;
      instr_vld_ff <= 1'b0;
    end else if (state_ff == dmc_pkg::DMC_INJ) begin
      instr_ff     <= INJ_INSTR_I;
      instr_vld_ff <= INJ_VALID_I;
    end else begin
      instr_ff     <= MEM_INSTR_I;
      instr_vld_ff <= (state_ff == dmc_pkg::DMC_EXEC) ||
                      (state_ff == dmc_pkg::DMC_STEP);
    end
  end

  // data-bus path to internal state; reads pass every cycle, writes only in injected mode
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rdata_ff <= '0;
      wdata_ff <= '0;
      we_ff    <= 1'b0;
    end else begin
      rdata_ff <= STATE_RDATA_I;
      wdata_ff <= DBG_WDATA_I;
      we_ff    <= DBG_WE_I && (state_ff == dmc_pkg::DMC_INJ);
    end
  end

  // mode status outputs
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_ff <= dmc_pkg::MODE_RESET;
    end else begin
      mode_ff <= mode_of(nxt_state);
    end
  end

  // pipeline permissions: halt stops both fetch and execute
  assign PIPE_O.fetch_en     = (state_ff == dmc_pkg::DMC_EXEC) ||
                               (state_ff == dmc_pkg::DMC_STEP);
  assign PIPE_O.exec_en      = PIPE_O.fetch_en ||
                               (state_ff == dmc_pkg::DMC_INJ);
  assign PIPE_O.use_injected = (state_ff == dmc_pkg::DMC_INJ);
  assign PIPE_O.outputs_off  = (state_ff == dmc_pkg::DMC_TEST);

  // drivers forced off in test mode (also the slave checker role)
  assign PIN_OE_O = PIPE_O.outputs_off ? '0 : DRV_OE_I;

  assign INSTR_O       = instr_ff;
  assign INSTR_VALID_O = instr_vld_ff;
  assign RESUME_PC_O   = saved_pc_ff;
  assign RESUME_O      = resume_ff;
  assign STATE_WDATA_O = wdata_ff;
  assign STATE_WE_O    = we_ff;
  assign DBG_RDATA_O   = rdata_ff;
  assign MODE_O        = mode_ff;

  dmc_out_check #(
    .W (PIN_W)
  ) u_chk (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .drive_i (DRV_VAL_I),
    .oe_i    (PIN_OE_O),
    .pin_i   (PIN_LVL_I),
    .slave_i (PIPE_O.outputs_off),
    .err_o   (CHK_ERR_O)
  );

  property p_halt_stop;
    @(posedge CLK_I) disable iff (!RST_N_I)
      state_ff == dmc_pkg::DMC_HALT |-> !PIPE_O.fetch_en && !PIPE_O.exec_en;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt runs");

  property p_halt_entry;
    @(posedge CLK_I) disable iff (!RST_N_I)
      state_ff == dmc_pkg::DMC_EXEC && HALT_INSTR_I && !CTRL_I.reset_req &&
      !CTRL_I.test_req |=> state_ff == dmc_pkg::DMC_HALT;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("no halt");

  property p_step_one;
    @(posedge CLK_I) disable iff (!RST_N_I)
      $rose(state_ff == dmc_pkg::DMC_STEP) && !CTRL_I.reset_req
      |-> PIPE_O.exec_en ##1 (state_ff != dmc_pkg::DMC_STEP);
  endproperty
  a_step_one: assert property (p_step_one) else $error("step len");

  property p_reset_wins;
    @(posedge CLK_I) disable iff (!RST_N_I)
      CTRL_I.reset_req |=> state_ff == dmc_pkg::DMC_RESET;
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("no reset");

  property p_test_off;
    @(posedge CLK_I) disable iff (!RST_N_I)
      state_ff == dmc_pkg::DMC_TEST |-> PIN_OE_O == '0;
  endproperty
  a_test_off: assert property (p_test_off) else $error("drivers on");

  property p_resume;
    @(posedge CLK_I) disable iff (!RST_N_I)
      state_ff == dmc_pkg::DMC_INJ && nxt_state == dmc_pkg::DMC_HALT
      |=> RESUME_O && RESUME_PC_O == $past(saved_pc_ff);
  endproperty
  a_resume: assert property (p_resume) else $error("pos lost");

  property p_save;
    @(posedge CLK_I) disable iff (!RST_N_I)
      state_ff != dmc_pkg::DMC_INJ && nxt_state == dmc_pkg::DMC_INJ
      |=> RESUME_PC_O == $past(PC_I);
  endproperty
  a_save: assert property (p_save)
    else $error("position not saved");

  property p_inject;
    @(posedge CLK_I) disable iff (!RST_N_I)
      state_ff == dmc_pkg::DMC_INJ |=> INSTR_O == $past(INJ_INSTR_I);
  endproperty
  a_inject: assert property (p_inject) else $error("wrong source");

  property p_mode;
    @(posedge CLK_I) disable iff (!RST_N_I)
      1'b1 |=> MODE_O == mode_of(state_ff);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");

  c_step:   cover property (@(posedge CLK_I) state_ff == dmc_pkg::DMC_STEP);
  c_inj:    cover property (@(posedge CLK_I) RESUME_O);
  c_test:   cover property (@(posedge CLK_I) state_ff == dmc_pkg::DMC_TEST);
  c_chkerr: cover property (@(posedge CLK_I) CHK_ERR_O);

endmodule : dmc_top

// ==== design/dmc_pkg.sv ====
// dmc_pkg: shared constants and carriers of the debug mode controller.
// assumes one synchronous clock domain and no software-visible registers.
package dmc_pkg;

  // number of checked output pins
  localparam int PIN_W = 8;
  // width of the instruction and data buses
  localparam int BUS_W = 32;
  // debugger-facing mode encoding on the status outputs
  localparam logic [2:0] MODE_EXEC  = 3'h0;
  localparam logic [2:0] MODE_HALT  = 3'h1;
  localparam logic [2:0] MODE_STEP  = 3'h2;
  localparam logic [2:0] MODE_INJ   = 3'h3;
  localparam logic [2:0] MODE_TEST  = 3'h4;
  localparam logic [2:0] MODE_RESET = 3'h5;
  // cycles spent executing per single step: one pipeline stage
  localparam logic [1:0] STEP_CYC  = 2'h1;
  // reset values
  localparam logic [BUS_W-1:0] PC_RST = 32'h0000_0000;

  // controller state, gray coded along exec-halt-step-inject
  typedef enum logic [2:0] {
    DMC_RESET = 3'b000,
    DMC_EXEC  = 3'b001,
    DMC_HALT  = 3'b011,
    DMC_STEP  = 3'b010,
    DMC_INJ   = 3'b110,
    DMC_TEST  = 3'b111
  } dmc_state_t;

  // debugger control inputs
  typedef struct packed {
    logic reset_req;
    logic halt_req;
    logic step_req;
    logic inject_req;
    logic test_req;
  } dmc_ctrl_t;

  // pipeline permission outputs
  typedef struct packed {
    logic fetch_en;
    logic exec_en;
    logic use_injected;
    logic outputs_off;
  } dmc_pipe_t;

endpackage : dmc_pkg

// ==== design/dmc_out_check.sv ====
// dmc_out_check: per-pin comparison of pin level against driver value.
// assumes pin levels are sampled back synchronously to CLK_I.
`timescale 1ns/1ps
module dmc_out_check #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] drive_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic         slave_i,
  output logic              err_o
);

  logic [W-1:0] miss;
  logic         err_ff;

  // one comparator per output; a slave compares against its own values
  // although its drivers are off, which is what catches open pins
  for (genvar g = 0; g < W; g++) begin : g_cmp
    assign miss[g] = (oe_i[g] | slave_i) &
                     (pin_i[g] ^ drive_i[g]);
  end

  // registered so the flag is glitch free
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= |miss;
    end
  end
  assign err_o = err_ff;

  property p_err_follows;
    @(posedge clk_i) disable iff (!rst_n_i)
      |miss |=> err_o;
  endproperty
  a_err_follows: assert property (p_err_follows)
    else $error("mismatch not flagged");

  property p_no_false;
    @(posedge clk_i) disable iff (!rst_n_i)
      !(|miss) |=> !err_o;
  endproperty
  a_no_false: assert property (p_no_false)
    else $error("false mismatch flag");

endmodule : dmc_out_check

// ==== tb/dmc_dev_model.sv ====
// dmc_dev_model: debugger instruction source and board pin wiring.
// assumes the bench changes inputs at the falling edge of CLK_I.
`timescale 1ns/1ps
module dmc_dev_model (
  input  wire logic                      clk_i,
  input  wire logic                      use_inj_i,
  input  wire logic [dmc_pkg::PIN_W-1:0] oe_i,
  input  wire logic [dmc_pkg::PIN_W-1:0] drv_i,
  input  wire logic [dmc_pkg::PIN_W-1:0] ext_i,
  input  wire logic [dmc_pkg::PIN_W-1:0] flt_i,
  output logic [31:0]                    instr_o,
  output logic                           valid_o,
  output logic [dmc_pkg::PIN_W-1:0]      pin_o
);
  // enabled core driver wins, a board fault flips it; else the test rig
  always_comb pin_o = (oe_i & (drv_i ^ flt_i)) | (~oe_i & ext_i);
  // a fresh word each cycle while injecting; the idle bus keeps toggling
  // so a stale value can never pass for a real one
  initial begin
    instr_o = 32'h1357_9bdf;
    valid_o = 1'b0;
    forever begin
      @(negedge clk_i);
      instr_o <= use_inj_i ? instr_o + 32'h0404_1011 : ~instr_o;
      valid_o <= use_inj_i;
    end
  end
endmodule : dmc_dev_model

// ==== tb/tb.sv ====
// tb: self-checking bench of the debug mode controller.
// assumes one-cycle registered latencies of the controller outputs.
`timescale 1ns/1ps
module tb;
  logic              clk;
  logic              rst_n;
  dmc_pkg::dmc_ctrl_t ctl;
  dmc_pkg::dmc_pipe_t pipe;
  logic              hin, dwe, ival, we, rsm, err, iv;
  logic [31:0]       pc, dwd, srd, mem, inj, ins, rpc, swd, rd, li, ei;
  logic [31:0]       seed = 32'h0000_0023;
  logic [7:0]        drv, doe, ext, flt, pin, poe;
  logic [2:0]        md;
  logic              lv;
  int                checks = 0;
  int                n_fail = 0;
  // expected state words: mode then fetch, exec, inject, outputs off
  localparam logic [31:0] X_RST  = 32'({dmc_pkg::MODE_RESET, 4'h0});
  localparam logic [31:0] X_EXEC = 32'({dmc_pkg::MODE_EXEC, 4'hc});
  localparam logic [31:0] X_HALT = 32'({dmc_pkg::MODE_HALT, 4'h0});
  localparam logic [31:0] X_STEP = 32'({dmc_pkg::MODE_STEP, 4'hc});
  localparam logic [31:0] X_INJ  = 32'({dmc_pkg::MODE_INJ, 4'h6});

  dmc_top i_dmc_top (.CLK_I(clk), .RST_N_I(rst_n), .CTRL_I(ctl),
    .HALT_INSTR_I(hin), .PC_I(pc), .INJ_INSTR_I(inj), .INJ_VALID_I(ival),
    .MEM_INSTR_I(mem), .DBG_WDATA_I(dwd), .DBG_WE_I(dwe),
    .STATE_RDATA_I(srd), .DRV_VAL_I(drv), .DRV_OE_I(doe), .PIN_LVL_I(pin),
    .PIPE_O(pipe), .INSTR_O(ins), .INSTR_VALID_O(iv), .RESUME_PC_O(rpc),
    .RESUME_O(rsm), .STATE_WDATA_O(swd), .STATE_WE_O(we),
    .DBG_RDATA_O(rd), .PIN_OE_O(poe), .MODE_O(md), .CHK_ERR_O(err));
  dmc_dev_model i_dmc_dev_model (.clk_i(clk), .use_inj_i(pipe.use_injected),
    .oe_i(poe), .drv_i(drv), .ext_i(ext), .flt_i(flt), .instr_o(inj),
    .valid_o(ival), .pin_o(pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // xorshift keeps every run identical
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // error expected from what the pins must show
  function automatic logic [31:0] exp_err(input logic [7:0] oe, d, x, f,
                                          input logic tst);
    logic [7:0] p;
    p = tst ? x : (oe & (d ^ f)) | (~oe & x);
    return 32'(|((tst ? 8'hff : oe) & (p ^ d)));
  endfunction : exp_err

  function automatic logic [31:0] st();
    return 32'({md, pipe});
  endfunction : st

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // one cycle; the read path is a copy of the state bus every cycle
  task automatic tick();
    logic [31:0] r;
    r = srd;
    @(negedge clk);
    #1;
    if (rst_n) chk(rd, r);
    srd = rnd();
    mem = rnd();
  endtask : tick

  // a hang is cut short here and counted
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    ctl = '0; rst_n = 1'b0; hin = 1'b0; dwe = 1'b0; pc = '0; dwd = '0;
    srd = '0; mem = '0; drv = '0; doe = '0; ext = '0; flt = '0;
    repeat (3) tick();
    chk(st(), X_RST);
    chk(32'(err), 32'h0);
    rst_n = 1'b1;
    tick();
    chk(st(), X_EXEC);
    $display("test reset done");
    ctl.halt_req = 1'b1;
    for (int i = 0; i < 5; i++) begin
      tick();
      chk(st(), X_HALT);
    end
    for (int i = 0; i < 3; i++) begin
      ctl.step_req = 1'b1;
      tick();
      chk(st(), X_STEP);
      ctl.step_req = 1'b0;
      tick();
      chk(st(), X_HALT);
    end
    $display("test halt_step done");
    dwe = 1'b1;
    tick();
    chk(32'(we), 32'h0);
    dwe = 1'b0;
    pc = rnd();
    li = pc;
    ctl.inject_req = 1'b1;
    tick();
    chk(st(), X_INJ);
    pc = rnd();
    for (int i = 0; i < 5; i++) begin
      dwd = rnd();
      dwe = i[0];
      lv = ival;
      ei = inj;
      tick();
      chk(ins, ei);
      chk(32'(iv), 32'(lv));
      chk(32'(we), 32'(dwe));
      if (dwe) chk(swd, dwd);
    end
    dwe = 1'b0;
    ctl.inject_req = 1'b0;
    tick();
    chk(st(), X_HALT);
    chk(32'(rsm), 32'h1);
    chk(rpc, li);
    tick();
    chk(32'(rsm), 32'h0);
    $display("test inject done");
    ctl.test_req = 1'b1;
    tick();
    chk(32'(md), 32'(dmc_pkg::MODE_TEST));
    chk(32'(poe), 32'h0);
    chk(32'(pipe.outputs_off), 32'h1);
    for (int i = 0; i < 6; i++) begin
      drv = 8'(rnd());
      ext = i == 0 ? drv : 8'(rnd());
      tick();
      chk(32'(err), exp_err(doe, drv, ext, flt, 1'b1));
    end
    ctl.test_req = 1'b0;
    tick();
    chk(st(), X_HALT);
    ctl.halt_req = 1'b0;
    tick();
    chk(st(), X_EXEC);
    $display("test slave done");
    for (int i = 0; i < 16; i++) begin
      doe = i == 1 ? 8'h00 : 8'(rnd());
      drv = 8'(rnd());
      ext = 8'(rnd());
      flt = i < 3 ? (i == 1 ? 8'hff : 8'h00) : 8'(rnd()) & (8'h01 << i % 8);
      tick();
      chk(32'(poe), 32'(doe));
      chk(32'(err), exp_err(doe, drv, ext, flt, 1'b0));
    end
    flt = '0;
    hin = 1'b1;
    tick();
    chk(st(), X_HALT);
    hin = 1'b0;
    tick();
    chk(st(), X_EXEC);
    $display("test check done");
    ctl = '1;
    tick();
    chk(st(), X_RST);
    ctl = '0;
    tick();
    chk(st(), X_EXEC);
    $display("test priority done");
    tally_and_finish();
  end
endmodule : tb
